// *** core/bit_shift_flag_datapath.v ***
// Purpose: bit, shift and flag operations of an 8-bit core over a
//          lite bus, with a read-modify-write port to the I/O space
// Assumes: I/O read data is valid in the cycle its address is shown
// Notes:   writing an op code to the control register starts it
//
// Overview of operation
// - branch on overflow clear: pc+k+1 when V is 0, 1/2 cycles, no flags.
// - branch on I set or I clear to pc+k+1, 1/2 cycles, no flags.
// - I/O bit set or clear forces one bit, others kept, two cycles.
// - logical shifts insert zero, one cycle, update Z, C, N, V.
// - rotate left: bit 0 from old carry, carry from old bit 7.
// - rotate right: bit 7 from old carry, carry from old bit 0.
// - arithmetic right shift keeps bit 7, one cycle, updates Z, C, N, V.
// - store copies a register bit to T; load copies T to a bit.
// - single-cycle set and clear of carry, negative and zero flags.
// - single-cycle set and clear of the overflow flag only.
// - global interrupt enable sets I, disable clears I, one cycle.
// - single-cycle set and clear of the signed test flag only.
// - single-cycle set and clear of half carry and of T flags.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "bit_shift_flag_regs.vh"
`default_nettype none

module bit_shift_flag_datapath (
	// clock and reset
	input  wire                clk_sys_i,
	input  wire                srst_i,
	// lite bus write address and data
	input  wire [`ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire                s_axi_awvalid_i,
	output wire                s_axi_awready_o,
	input  wire [31:0]         s_axi_wdata_i,
	input  wire [3:0]          s_axi_wstrb_i,
	input  wire                s_axi_wvalid_i,
	output wire                s_axi_wready_o,
	output reg  [1:0]          s_axi_bresp_o,
	output reg                 s_axi_bvalid_o,
	input  wire                s_axi_bready_i,
	// lite bus read
	input  wire [`ADDR_W-1:0]  s_axi_araddr_i,
	input  wire                s_axi_arvalid_i,
	output wire                s_axi_arready_o,
	output reg  [31:0]         s_axi_rdata_o,
	output reg  [1:0]          s_axi_rresp_o,
	output reg                 s_axi_rvalid_o,
	input  wire                s_axi_rready_i,
	// I/O space
	output wire [4:0]          io_addr_o,
	input  wire [7:0]          io_rdata_i,
	output reg  [7:0]          io_wdata_o,
	output reg                 io_we_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	// software-visible state
	reg  [31:0]        operand_q;
	reg  [31:0]        branch_q;
	reg  [4:0]         io_addr_q;
	reg  [7:0]         status_flags_reg_q;
	reg  [7:0]         res_lo_q;
	reg  [7:0]         res_hi_q;
	reg                res_wr_q;
	reg  [15:0]        next_pc_q;
	reg                taken_q;
	reg  [2:0]         cycles_q;
	reg  [`OP_W-1:0]   op_q;
	reg                state_q;
	reg  [7:0]         io_byte_q;

	// bus capture
	reg                aw_full_q;
	reg  [`ADDR_W-1:0] aw_addr_q;
	reg                w_full_q;
	reg  [31:0]        w_data_q;
	reg  [3:0]         w_strb_q;

	wire               wr_fire;
	wire [31:0]        wmask;
	wire [`OP_W-1:0]   op_new;
	wire               start;
	wire [7:0]         opnd_rd;
	wire [7:0]         opnd_rr;
	wire [7:0]         opnd_k;
	wire [2:0]         opnd_bit;
	wire [15:0]        br_pc;
	wire [15:0]        br_k_ext;
	wire [7:0]         sh_res;
	wire               sh_c;
	wire [7:0]         bit_onehot;
	reg                br_cond;
	reg                wr_known;

	// ==========================================================
	// bus handshakes
	assign s_axi_awready_o = !aw_full_q;
	assign s_axi_wready_o  = !w_full_q;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
	assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign op_new  = w_data_q[`OP_W-1:0];
	// a new op is refused while the previous one is still busy
	assign start   = wr_fire && (aw_addr_q == `OFS_CTRL) &&
		w_strb_q[0] && (state_q == ST_IDLE);

	// operand fields
	assign opnd_rd  = operand_q[`OPND_RD_LSB +: 8];
	assign opnd_rr  = operand_q[`OPND_RR_LSB +: 8];
	assign opnd_k   = operand_q[`OPND_K_LSB +: 8];
	assign opnd_bit = operand_q[`OPND_BIT_LSB +: 3];
	assign br_pc    = branch_q[`BR_PC_LSB +: 16];
	assign br_k_ext = {{(16-`BR_K_W){branch_q[`BR_K_LSB+`BR_K_W-1]}},
		branch_q[`BR_K_LSB +: `BR_K_W]};
	assign io_addr_o = io_addr_q;

	// one-hot mask of the selected bit
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_onehot
			assign bit_onehot[gi] = (opnd_bit == gi);
		end
	endgenerate

	shift_rotate_unit u_shift (
		.op_i     (op_new),
		.value_i  (opnd_rd),
		.carry_i  (status_flags_reg_q[`FLG_C]),
		.result_o (sh_res),
		.carry_o  (sh_c)
	);

	// branch condition per op
	always @* begin
		case (op_new)
			`OP_BR_OVF_CLEAR:
				br_cond = !status_flags_reg_q[`FLG_V];
			`OP_BR_IRQ_ENABLED:
				br_cond = status_flags_reg_q[`FLG_I];
			`OP_BR_IRQ_DISABLED:
				br_cond = !status_flags_reg_q[`FLG_I];
			default:
				br_cond = 1'b0;
		endcase
	end

	// address decode for writes
	always @* begin
		case (aw_addr_q)
			`OFS_CTRL, `OFS_OPERAND, `OFS_BRANCH, `OFS_FLAGS,
			`OFS_IO_ADDR, `OFS_RESULT, `OFS_NEXT_PC:
				wr_known = 1'b1;
			default:
				wr_known = 1'b0;
		endcase
	end

	// ==========================================================
	// write channel capture and response
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			aw_full_q      <= 1'b0;
			aw_addr_q      <= {`ADDR_W{1'b0}};
			w_full_q       <= 1'b0;
			w_data_q       <= 32'h0000_0000;
			w_strb_q       <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_full_q      <= 1'b0;
				w_full_q       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read channel
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= `RESP_OKAY;
		end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= `RESP_OKAY;
			case (s_axi_araddr_i)
				`OFS_CTRL:
					s_axi_rdata_o <= {22'h0, cycles_q,
						(state_q == ST_WAIT), op_q};
				`OFS_OPERAND: s_axi_rdata_o <= operand_q;
				`OFS_BRANCH:  s_axi_rdata_o <= branch_q;
				`OFS_FLAGS:
					s_axi_rdata_o <= {24'h000000, status_flags_reg_q};
				`OFS_RESULT:
					s_axi_rdata_o <= {15'h0000, res_wr_q, res_hi_q,
						res_lo_q};
				`OFS_NEXT_PC:
					s_axi_rdata_o <= {15'h0000, taken_q, next_pc_q};
				`OFS_IO_ADDR:
					s_axi_rdata_o <= {19'h00000, io_byte_q, io_addr_q};
				default: begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ==========================================================
	// operand registers written by software
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			operand_q <= 32'h0000_0000;
			branch_q  <= 32'h0000_0000;
			io_addr_q <= 5'h00;
		end else if (wr_fire) begin
			if (aw_addr_q == `OFS_OPERAND)
				operand_q <= (operand_q & ~wmask) | (w_data_q & wmask);
			if (aw_addr_q == `OFS_BRANCH)
				branch_q <= (branch_q & ~wmask) | (w_data_q & wmask);
			if (aw_addr_q == `OFS_IO_ADDR && w_strb_q[0])
				io_addr_q <= w_data_q[4:0];
		end
	end

	// ==========================================================
	// sequencer and execution
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_q            <= ST_IDLE;
			op_q               <= `OP_NONE;
			status_flags_reg_q <= `FLAGS_RST;
			res_lo_q           <= 8'h00;
			res_hi_q           <= 8'h00;
			res_wr_q           <= 1'b0;
			next_pc_q          <= 16'h0000;
			taken_q            <= 1'b0;
			cycles_q           <= 3'h0;
			io_byte_q          <= 8'h00;
			io_wdata_o         <= 8'h00;
			io_we_o            <= 1'b0;
		end else begin
			io_we_o <= 1'b0;
			// direct software write of the status byte
			if (wr_fire && aw_addr_q == `OFS_FLAGS && w_strb_q[0])
				status_flags_reg_q <= w_data_q[7:0];
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						op_q     <= op_new;
						res_wr_q <= 1'b0;
						taken_q  <= 1'b0;
						cycles_q <= `CYC_ONE;
						next_pc_q <= br_pc + 16'h0001;
						case (op_new)
							`OP_BR_OVF_CLEAR, `OP_BR_IRQ_ENABLED,
							`OP_BR_IRQ_DISABLED: begin
								if (br_cond) begin
									next_pc_q <= br_pc + br_k_ext +
										16'h0001;
									taken_q  <= 1'b1;
									cycles_q <= `CYC_TWO;
									state_q  <= ST_WAIT;
								end
							end
							`OP_IO_BIT_SET, `OP_IO_BIT_CLEAR: begin
								// read phase of read-modify-write
								io_byte_q <= io_rdata_i;
								cycles_q  <= `CYC_TWO;
								state_q   <= ST_WAIT;
							end
							`OP_SHIFT_LEFT, `OP_SHIFT_RIGHT,
							`OP_ROT_LEFT_C, `OP_ROT_RIGHT_C,
							`OP_ARITH_RIGHT: begin
								res_lo_q <= sh_res;
								res_wr_q <= 1'b1;
								status_flags_reg_q[`FLG_Z] <=
									(sh_res == 8'h00);
								status_flags_reg_q[`FLG_C] <= sh_c;
								status_flags_reg_q[`FLG_N] <= sh_res[7];
								status_flags_reg_q[`FLG_V] <=
									sh_res[7] ^ sh_c;
							end
							`OP_NIBBLE_SWAP: begin
								res_lo_q <= sh_res;
								res_wr_q <= 1'b1;
							end
							`OP_FLAG_SET_GENERIC:
								status_flags_reg_q[opnd_bit] <=
									1'b1;
							`OP_FLAG_CLR_GENERIC:
								status_flags_reg_q[opnd_bit] <=
									1'b0;
							`OP_BIT_TO_T:
								status_flags_reg_q[`FLG_T] <=
									opnd_rr[opnd_bit];
							`OP_T_TO_BIT: begin
								res_lo_q <= status_flags_reg_q[`FLG_T] ?
									(opnd_rd | bit_onehot) :
									(opnd_rd & ~bit_onehot);
								res_wr_q <= 1'b1;
							end
							`OP_REG_MOVE: begin
								res_lo_q <= opnd_rr;
								res_wr_q <= 1'b1;
							end
							`OP_WORD_PAIR_COPY: begin
								res_lo_q <= opnd_rr;
								res_hi_q <= opnd_k;
								res_wr_q <= 1'b1;
							end
							`OP_IMMEDIATE_LOAD: begin
								res_lo_q <= opnd_k;
								res_wr_q <= 1'b1;
							end
							default: begin
								// named flag ops: code bit 0 set/clear,
								// bits 3:1 pick the flag
								if (op_new[5:4] == 2'h1)
									status_flags_reg_q[op_new[3:1]] <=
										!op_new[0];
							end
						endcase
					end
				end
				ST_WAIT: begin
					// second cycle: write phase of I/O update
					if (op_q == `OP_IO_BIT_SET) begin
						io_wdata_o <= io_byte_q | bit_onehot;
						io_we_o    <= 1'b1;
					end else if (op_q == `OP_IO_BIT_CLEAR) begin
						io_wdata_o <= io_byte_q & ~bit_onehot;
						io_we_o    <= 1'b1;
					end
					state_q <= ST_IDLE;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** core/bit_shift_flag_regs.vh ***
// Purpose: constants shared by the bit, shift and flag datapath
// Assumes: status byte layout C,Z,N,V,S,H,T,I from bit 0 upward
// Notes:   byte addresses of the control registers on the lite bus
`ifndef BIT_SHIFT_FLAG_REGS_VH
`define BIT_SHIFT_FLAG_REGS_VH

// ==========================================================
// register byte addresses
`define ADDR_W          8
`define OFS_CTRL        8'h00
`define OFS_OPERAND     8'h04
`define OFS_BRANCH      8'h08
`define OFS_FLAGS       8'h0C
`define OFS_RESULT      8'h10
`define OFS_NEXT_PC     8'h14
`define OFS_IO_ADDR     8'h18

// ==========================================================
// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ==========================================================
// status flag bit positions
`define FLG_C           3'h0
`define FLG_Z           3'h1
`define FLG_N           3'h2
`define FLG_V           3'h3
`define FLG_S           3'h4
`define FLG_H           3'h5
`define FLG_T           3'h6
`define FLG_I           3'h7
`define FLAGS_RST       8'h00

// ==========================================================
// operation codes written to the control register
`define OP_W                  6
`define OP_NONE               6'h00
`define OP_BR_OVF_CLEAR       6'h01
`define OP_BR_IRQ_ENABLED     6'h02
`define OP_BR_IRQ_DISABLED    6'h03
`define OP_IO_BIT_SET         6'h04
`define OP_IO_BIT_CLEAR       6'h05
`define OP_SHIFT_LEFT         6'h06
`define OP_SHIFT_RIGHT        6'h07
`define OP_ROT_LEFT_C         6'h08
`define OP_ROT_RIGHT_C        6'h09
`define OP_ARITH_RIGHT        6'h0A
`define OP_NIBBLE_SWAP        6'h0B
`define OP_FLAG_SET_GENERIC   6'h0C
`define OP_FLAG_CLR_GENERIC   6'h0D
`define OP_BIT_TO_T           6'h0E
`define OP_T_TO_BIT           6'h0F
`define OP_NAMED_FLAG_BASE    6'h10
`define OP_REG_MOVE           6'h20
`define OP_WORD_PAIR_COPY     6'h21
`define OP_IMMEDIATE_LOAD     6'h22

// ==========================================================
// operand register fields
`define OPND_RD_LSB     0
`define OPND_RR_LSB     8
`define OPND_K_LSB      16
`define OPND_BIT_LSB    24
`define BR_PC_LSB       0
`define BR_K_LSB        16
`define BR_K_W          7

// ==========================================================
// cycle counts
`define CYC_ONE         3'h1
`define CYC_TWO         3'h2

`endif

// *** core/shift_rotate_unit.v ***
// Purpose: one-place shifts, rotates through carry and nibble swap
// Assumes: op code selects the function, value and carry are stable
// Notes:   purely combinational, the caller registers the result
`include "bit_shift_flag_regs.vh"
`default_nettype none

module shift_rotate_unit (
	// operation and operands
	input  wire [`OP_W-1:0] op_i,
	input  wire [7:0]       value_i,
	input  wire             carry_i,
	// result
	output reg  [7:0]       result_o,
	output reg              carry_o
);

	// ==========================================================
	// function select
	always @* begin
		result_o = value_i;
		carry_o  = carry_i;
		case (op_i)
			`OP_SHIFT_LEFT: begin
				result_o = {value_i[6:0], 1'b0};
				carry_o  = value_i[7];
			end
			`OP_SHIFT_RIGHT: begin
				result_o = {1'b0, value_i[7:1]};
				carry_o  = value_i[0];
			end
			`OP_ROT_LEFT_C: begin
				result_o = {value_i[6:0], carry_i};
				carry_o  = value_i[7];
			end
			`OP_ROT_RIGHT_C: begin
				result_o = {carry_i, value_i[7:1]};
				carry_o  = value_i[0];
			end
			`OP_ARITH_RIGHT: begin
				result_o = {value_i[7], value_i[7:1]};
				carry_o  = value_i[0];
			end
			`OP_NIBBLE_SWAP: begin
				result_o = {value_i[3:0], value_i[7:4]};
			end
			default: begin
				result_o = value_i;
				carry_o  = carry_i;
			end
		endcase
	end

endmodule

`default_nettype wire

// *** verif/bit_shift_flag_datapath_asserts.sv ***
// Purpose: port timing checks for the bit, shift and flag datapath
// Assumes: one write and one read outstanding at a time
// Notes:   attached by bind from the bench top
`default_nettype none

module bit_shift_flag_datapath_asserts (
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	// lite bus
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// I/O space
	input wire logic [4:0]  io_addr_o,
	input wire logic        io_we_o
);
	// ==========================================================
	// handshake steps
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence

	// ==========================================================
	// assertions
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b dropped");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("r dropped");
	AST_B_TIME: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
		else $error("write answer late");
	AST_R_TIME: assert property (rd_taken |=> s_axi_rvalid_o)
		else $error("read answer late");
	AST_AR_RDY: assert property (rd_taken |=> !s_axi_arready_o)
		else $error("arready wrong");
	AST_B_ONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
		!s_axi_bvalid_o) else $error("b repeated");
	AST_IO_PULSE: assert property (io_we_o |=> !io_we_o)
		else $error("io write too long");
	AST_IO_ADDR: assert property (io_we_o |-> $stable(io_addr_o))
		else $error("io address moved");
	AST_IO_AFTER_B: assert property (io_we_o |-> $past(s_axi_bvalid_o))
		else $error("io write without a started op");
endmodule

`default_nettype wire

// *** verif/io_space_model.sv ***
// Purpose: I/O space on the far side of the datapath
// Assumes: zero-latency read of the addressed byte
// Notes:   bytes start from a fixed pattern
`default_nettype none

module io_space_model (
	// clock
	input  wire logic       clk_sys_i,
	// access port
	input  wire logic [4:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       we_i,
	output wire logic [7:0] rdata_o
);
	logic [7:0] mem [32];

	// preset pattern
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 8'(i * 29 + 7);
	end

	// combinational read, write on pulse
	assign rdata_o = mem[addr_i];
	always @(posedge clk_sys_i) begin
		if (we_i) mem[addr_i] <= wdata_i;
	end
endmodule

`default_nettype wire

// *** verif/tb_bit_shift_flag_datapath.sv ***
// Purpose: self-checking bench for the bit, shift and flag datapath
// Assumes: lite bus master, I/O space model on the far side
// Notes:   expected values come from a bench model of each operation
`include "bit_shift_flag_regs.vh"
`default_nettype none

module tb_bit_shift_flag_datapath;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// signals
	logic        clk_sys_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  s_axi_awaddr_i = 8'h00;
	logic [7:0]  s_axi_araddr_i = 8'h00;
	logic        s_axi_awvalid_i = 1'b0;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_bready_i = 1'b1;
	logic        s_axi_rready_i = 1'b1;
	wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire         s_axi_arready_o, s_axi_rvalid_o, io_we_o;
	wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	wire  [31:0] s_axi_rdata_o;
	wire  [4:0]  io_addr_o;
	wire  [7:0]  io_rdata_i, io_wdata_o;
	int          err_total = 0;
	int          checked = 0;
	logic [31:0] opnd, brn, got;
	logic [15:0] er, npc;
	logic [7:0]  fl, ef, ob, nb;
	logic [5:0]  op;
	logic [4:0]  ia;
	logic [2:0]  cy;
	logic [1:0]  rs;
	logic        tk, hr;

	// ==========================================================
	// design, far side and clock
	bit_shift_flag_datapath u_bit_shift_flag_datapath (.clk_sys_i, .srst_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .io_addr_o, .io_rdata_i, .io_wdata_o, .io_we_o);
	io_space_model u_io_space_model (.clk_sys_i, .addr_i(io_addr_o),
		.wdata_i(io_wdata_o), .we_i(io_we_o), .rdata_o(io_rdata_i));
	always #10 clk_sys_i = ~clk_sys_i;

	// ==========================================================
	// report, compare and bus tasks
	task automatic give_verdict;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		chk_val({30'h0, g}, {30'h0, e});
	endtask
	task automatic hang_chk(input int n);
		if (n >= 40) begin
			err_total++;
			give_verdict;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o === 1'b1) break;
		end
		r = s_axi_bresp_o;
		hang_chk(n);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o === 1'b1) break;
		end
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		hang_chk(n);
	endtask

	// ==========================================================
	// bench model: {carry, result} of shifts and swap
	function automatic logic [8:0] shf(input logic [5:0] o,
		input logic [7:0] d, input logic c);
		case (o)
			`OP_SHIFT_LEFT: return {d, 1'b0};
			`OP_SHIFT_RIGHT: return {d[0], 1'b0, d[7:1]};
			`OP_ROT_LEFT_C: return {d, c};
			`OP_ROT_RIGHT_C: return {d[0], c, d[7:1]};
			`OP_ARITH_RIGHT: return {d[0], d[7], d[7:1]};
			default: return {c, d[3:0], d[7:4]};
		endcase
	endfunction
	task automatic model;
		logic [8:0] e;
		logic [2:0] b;
		b = opnd[26:24];
		ef = fl;
		e = shf(op, opnd[7:0], fl[`FLG_C]);
		er = {8'h00, e[7:0]};
		tk = (op == `OP_BR_OVF_CLEAR && !fl[`FLG_V])
			|| (op == `OP_BR_IRQ_ENABLED && fl[`FLG_I])
			|| (op == `OP_BR_IRQ_DISABLED && !fl[`FLG_I]);
		npc = brn[15:0] + (tk ? {{9{brn[22]}}, brn[22:16]} : 16'h0) + 16'h1;
		cy = (tk || op == `OP_IO_BIT_SET || op == `OP_IO_BIT_CLEAR)
			? `CYC_TWO : `CYC_ONE;
		nb = op[0] ? ob & ~(8'h01 << b) : ob | (8'h01 << b);
		hr = (op >= `OP_SHIFT_LEFT && op <= `OP_NIBBLE_SWAP)
			|| op == `OP_T_TO_BIT
			|| (op >= `OP_REG_MOVE && op <= `OP_IMMEDIATE_LOAD);
		if (op >= `OP_SHIFT_LEFT && op < `OP_NIBBLE_SWAP)
			ef[3:0] = {e[7] ^ e[8], e[7], e[7:0] == 8'h00, e[8]};
		if (op >= `OP_NAMED_FLAG_BASE && op < `OP_REG_MOVE)
			ef[op[3:1]] = !op[0];
		case (op)
			`OP_FLAG_SET_GENERIC: ef[b] = 1'b1;
			`OP_FLAG_CLR_GENERIC: ef[b] = 1'b0;
			`OP_BIT_TO_T: ef[`FLG_T] = opnd[8 + b];
			`OP_T_TO_BIT: begin
				er = {8'h00, opnd[7:0]};
				er[b] = fl[`FLG_T];
			end
			`OP_REG_MOVE: er = {8'h00, opnd[15:8]};
			`OP_WORD_PAIR_COPY: er = opnd[23:8];
			`OP_IMMEDIATE_LOAD: er = {8'h00, opnd[23:16]};
			default: ;
		endcase
	endtask

	// ==========================================================
	// main sequence: reset, unmapped place, op codes 0x01 to 0x23 three times each
	initial begin
		void'($urandom(74));
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		axr(`OFS_FLAGS, got, rs);
		chk_val(got, {24'h0, `FLAGS_RST});
		axw(8'h1C, 32'h1, rs);
		chk_resp(rs, `RESP_SLVERR);
		axr(8'h1C, got, rs);
		chk_resp(rs, `RESP_SLVERR);
		for (int i = 0; i < 105; i++) begin
			op = 6'(i % 35 + 1);
			opnd = $urandom;
			brn = $urandom;
			fl = 8'($urandom);
			ia = 5'($urandom);
			if (i < 35) begin
				opnd[7:0] = 8'h80;
				brn[22:0] = 23'h40_FFFF;
			end
			ob = u_io_space_model.mem[ia];
			model();
			axw(`OFS_IO_ADDR, {27'h0, ia}, rs);
			axw(`OFS_OPERAND, opnd, rs);
			axw(`OFS_BRANCH, brn, rs);
			axw(`OFS_FLAGS, {24'h0, fl}, rs);
			axw(`OFS_CTRL, {26'h0, op}, rs);
			chk_resp(rs, `RESP_OKAY);
			axr(`OFS_FLAGS, got, rs);
			chk_val(got, {24'h0, ef});
			axr(`OFS_CTRL, got, rs);
			chk_val({23'h0, got[9:7], got[5:0]}, {23'h0, cy, op});
			if (hr) begin
				axr(`OFS_RESULT, got, rs);
				if (op != `OP_WORD_PAIR_COPY) got[15:8] = 8'h00;
				chk_val(32'(got[15:0]), 32'(er));
			end
			if (op <= `OP_BR_IRQ_DISABLED) begin
				axr(`OFS_NEXT_PC, got, rs);
				chk_val({15'h0, got[16:0]}, {15'h0, tk, npc});
			end
			if (op == `OP_IO_BIT_SET || op == `OP_IO_BIT_CLEAR) begin
				chk_val({24'h0, u_io_space_model.mem[ia]}, {24'h0, nb});
				axr(`OFS_IO_ADDR, got, rs);
				chk_val({24'h0, got[12:5]}, {24'h0, ob});
			end
		end
		give_verdict;
	end
endmodule

bind bit_shift_flag_datapath bit_shift_flag_datapath_asserts
	u_bit_shift_flag_datapath_asserts (.clk_sys_i, .srst_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .io_addr_o, .io_we_o);

`default_nettype wire
